// *** design/sfl_spi_frame.v ***
// Purpose: Serial slave frame engine: address, control and data phases
// Assumes: Mode 0 link; targets answer a read strobe with data one
//          clock later on i_acc_rdata
// Notes:   Rules carried by this block follow
// Behaviour
// - Direction bit one means write, zero means read.
// - Length mode 00 is variable length, 01 one byte, 10 two, 11 four.
// - In fixed mode select stays low and the data phase ends after N bytes.
// - In variable mode any number of bytes is taken until select rises.
// - Every byte travels most significant bit first on both data lines.
// - Further write bytes go to consecutive offsets in the chosen block.
// - Further read bytes come from consecutive offsets, one per byte time.
// - The block select field picks the target region of each access.
`timescale 1ns/1ps
`include "sfl_consts.vh"

module sfl_spi_frame (
    input  wire        i_clock,
    input  wire        i_rst_n,
    input  wire        i_sclk,
    input  wire        i_mosi,
    input  wire        i_frame_select_n,
    output reg         o_miso,
    output reg         o_miso_oe,
    output reg         o_acc_strobe,
    output reg         o_acc_write,
    output reg  [4:0]  o_acc_block,
    output reg  [15:0] o_acc_offset,
    output reg  [7:0]  o_acc_wdata,
    input  wire [7:0]  i_acc_rdata,
    input  wire [3:0]  i_avs_address,
    input  wire        i_avs_read,
    input  wire        i_avs_write,
    input  wire [31:0] i_avs_writedata,
    output reg  [31:0] o_avs_readdata,
    output reg         o_avs_waitrequest
);

// ----------------------------------------------------------------------
// Decoding and state codes
// ----------------------------------------------------------------------
localparam [2:0] ST_ADDR = 3'h1;
localparam [2:0] ST_CTRL = 3'h2;
localparam [2:0] ST_DATA = 3'h4;

function [2:0] mode_len;
    input [1:0] mode;
    begin
        case (mode)
            `SFL_MODE_ONE:  mode_len = `SFL_LEN_ONE;
            `SFL_MODE_TWO:  mode_len = `SFL_LEN_TWO;
            `SFL_MODE_FOUR: mode_len = `SFL_LEN_FOUR;
            default:        mode_len = `SFL_LEN_VAR;
        endcase
    end
endfunction

// ----------------------------------------------------------------------
// Pin synchronisers: a change counts once stages two and three agree
// ----------------------------------------------------------------------
reg  [2:0]  pin_s1_reg;
reg  [2:0]  pin_s2_reg;
reg  [2:0]  pin_s3_reg;
reg  [2:0]  pin_f_reg;
reg  [2:0]  pin_p_reg;
wire [2:0]  pin_raw = {i_frame_select_n, i_mosi, i_sclk};
wire [2:0]  pin_f_next = (pin_s2_reg ~^ pin_s3_reg) & pin_s3_reg
                       | (pin_s2_reg ^ pin_s3_reg) & pin_f_reg;

always @(posedge i_clock) begin
    if (!i_rst_n) begin
        pin_s1_reg <= `SFL_PIN_IDLE;
        pin_s2_reg <= `SFL_PIN_IDLE;
        pin_s3_reg <= `SFL_PIN_IDLE;
        pin_f_reg  <= `SFL_PIN_IDLE;
        pin_p_reg  <= `SFL_PIN_IDLE;
    end else begin
        pin_s1_reg <= pin_raw;
        pin_s2_reg <= pin_s1_reg;
        pin_s3_reg <= pin_s2_reg;
        pin_f_reg  <= pin_f_next;
        pin_p_reg  <= pin_f_reg;
    end
end

wire sel_low  = ~pin_f_reg[2];
wire sel_rise = pin_f_reg[2] & ~pin_p_reg[2];
wire mosi_f   = pin_f_reg[1];
wire sck_rise = pin_f_reg[0] & ~pin_p_reg[0];
wire sck_fall = ~pin_f_reg[0] & pin_p_reg[0];

// ----------------------------------------------------------------------
// Frame engine
// ----------------------------------------------------------------------
reg  [2:0]  state_reg;
reg  [4:0]  bit_cnt_reg;
reg  [14:0] shift_reg;
reg  [15:0] addr_reg;
reg  [4:0]  block_reg;
reg         dir_reg;
reg  [1:0]  mode_reg;
reg  [2:0]  len_reg;
reg  [15:0] bytes_reg;
reg         rd_pend_reg;
reg  [7:0]  rd_hold_reg;
reg  [7:0]  tx_reg;
reg  [15:0] frames_reg;
reg  [15:0] last_bytes_reg;
reg         enable_reg;
wire [7:0]  byte_in = {shift_reg[6:0], mosi_f};
wire        active  = enable_reg & sel_low;
wire [15:0] bytes_next = bytes_reg + 16'h0001;

always @(posedge i_clock) begin
    if (!i_rst_n) begin
        state_reg      <= ST_ADDR;
        bit_cnt_reg    <= 5'h00;
        shift_reg      <= 15'h0000;
        addr_reg       <= 16'h0000;
        block_reg      <= 5'h00;
        dir_reg        <= 1'h0;
        mode_reg       <= 2'h0;
        len_reg        <= 3'h0;
        bytes_reg      <= 16'h0000;
        rd_pend_reg    <= 1'h0;
        rd_hold_reg    <= 8'h00;
        tx_reg         <= 8'h00;
        frames_reg     <= 16'h0000;
        last_bytes_reg <= 16'h0000;
        o_miso         <= 1'h0;
        o_miso_oe      <= 1'h0;
        o_acc_strobe   <= 1'h0;
        o_acc_write    <= 1'h0;
        o_acc_block    <= 5'h00;
        o_acc_offset   <= 16'h0000;
        o_acc_wdata    <= 8'h00;
    end else begin
        o_acc_strobe <= 1'h0;
        rd_pend_reg  <= o_acc_strobe & ~o_acc_write;
        if (rd_pend_reg)
            rd_hold_reg <= i_acc_rdata;
        o_miso_oe <= active;
        if (!active) begin
            if (state_reg != ST_ADDR || bit_cnt_reg != 5'h00) begin
                state_reg      <= ST_ADDR;
                bit_cnt_reg    <= 5'h00;
                last_bytes_reg <= bytes_reg;
                frames_reg     <= frames_reg + 16'h0001;
            end
            bytes_reg <= 16'h0000;
        end else if (sck_rise) begin
            shift_reg   <= {shift_reg[13:0], mosi_f};
            bit_cnt_reg <= bit_cnt_reg + 5'h01;
            case (state_reg)
                ST_ADDR: begin
                    if (bit_cnt_reg == `SFL_ADDR_LAST) begin
                        addr_reg    <= {shift_reg, mosi_f};
                        state_reg   <= ST_CTRL;
                        bit_cnt_reg <= 5'h00;
                    end
                end
                ST_CTRL: begin
                    if (bit_cnt_reg == `SFL_BYTE_LAST) begin
                        block_reg   <= byte_in[`SFL_CTL_BLK_HI:
                                               `SFL_CTL_BLK_LO];
                        dir_reg     <= byte_in[`SFL_CTL_DIR];
                        mode_reg    <= byte_in[`SFL_CTL_MODE_HI:
                                               `SFL_CTL_MODE_LO];
                        len_reg     <= mode_len(byte_in[`SFL_CTL_MODE_HI:
                                               `SFL_CTL_MODE_LO]);
                        state_reg   <= ST_DATA;
                        bit_cnt_reg <= 5'h00;
                        bytes_reg   <= 16'h0000;
                        if (byte_in[`SFL_CTL_DIR] != `SFL_DIR_WRITE) begin
                            o_acc_strobe <= 1'h1;
                            o_acc_write  <= 1'h0;
                            o_acc_block  <= byte_in[`SFL_CTL_BLK_HI:
                                                    `SFL_CTL_BLK_LO];
                            o_acc_offset <= addr_reg;
                            addr_reg     <= addr_reg + 16'h0001;
                        end
                    end
                end
                ST_DATA: begin
                    if (bit_cnt_reg == `SFL_BYTE_LAST) begin
                        bit_cnt_reg <= 5'h00;
                        bytes_reg   <= bytes_next;
                        if (len_reg != `SFL_LEN_VAR &&
                            bytes_next[2:0] == len_reg) begin
                            state_reg      <= ST_ADDR;
                            last_bytes_reg <= bytes_next;
                            frames_reg     <= frames_reg + 16'h0001;
                            bytes_reg      <= 16'h0000;
                        end
                        if (dir_reg == `SFL_DIR_WRITE) begin
                            o_acc_strobe <= 1'h1;
                            o_acc_write  <= 1'h1;
                            o_acc_block  <= block_reg;
                            o_acc_offset <= addr_reg;
                            o_acc_wdata  <= byte_in;
                            addr_reg     <= addr_reg + 16'h0001;
                        end else if (len_reg == `SFL_LEN_VAR ||
                                     bytes_next[2:0] != len_reg) begin
                            o_acc_strobe <= 1'h1;
                            o_acc_write  <= 1'h0;
                            o_acc_block  <= block_reg;
                            o_acc_offset <= addr_reg;
                            addr_reg     <= addr_reg + 16'h0001;
                        end
                    end
                end
                default: begin
                    state_reg   <= ST_ADDR;
                    bit_cnt_reg <= 5'h00;
                end
            endcase
        end else if (sck_fall && state_reg == ST_DATA &&
                     dir_reg != `SFL_DIR_WRITE) begin
            if (bit_cnt_reg == 5'h00) begin
                o_miso <= rd_hold_reg[7];
                tx_reg <= {rd_hold_reg[6:0], 1'h0};
            end else begin
                o_miso <= tx_reg[7];
                tx_reg <= {tx_reg[6:0], 1'h0};
            end
        end
    end
end

// ----------------------------------------------------------------------
// Register bus slave: one wait cycle, then the answer
// ----------------------------------------------------------------------
always @(posedge i_clock) begin
    if (!i_rst_n) begin
        enable_reg        <= `SFL_CTRL_RST;
        o_avs_readdata    <= 32'h00000000;
        o_avs_waitrequest <= 1'h1;
    end else begin
        o_avs_waitrequest <= 1'h1;
        if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
            o_avs_waitrequest <= 1'h0;
            case (i_avs_address)
                `SFL_REG_CTRL:
                    o_avs_readdata <= {31'h00000000, enable_reg};
                `SFL_REG_STATUS:
                    o_avs_readdata <= {frames_reg, 8'h00, block_reg,
                                       dir_reg, mode_reg};
                `SFL_REG_COUNT:
                    o_avs_readdata <= {last_bytes_reg, bytes_reg};
                default:
                    o_avs_readdata <= 32'h00000000;
            endcase
        end
        if (i_avs_write && !o_avs_waitrequest &&
            i_avs_address == `SFL_REG_CTRL)
            enable_reg <= i_avs_writedata[`SFL_CTRL_EN];
    end
end

endmodule

// *** design/sfl_consts.vh ***
// Purpose: Constants for the serial frame engine with length modes
// Assumes: 100 MHz system clock, register bus with byte addresses
// Notes:   Included by sfl_spi_frame.v only
`ifndef SFL_CONSTS_VH
`define SFL_CONSTS_VH

// ----------------------------------------------------------------------
// Frame layout
// ----------------------------------------------------------------------
`define SFL_ADDR_LAST   5'h0F
`define SFL_BYTE_LAST   5'h07
`define SFL_CTL_BLK_HI  7
`define SFL_CTL_BLK_LO  3
`define SFL_CTL_DIR     2
`define SFL_CTL_MODE_HI 1
`define SFL_CTL_MODE_LO 0
`define SFL_DIR_WRITE   1'h1
// Idle pin levels {select, data, clock}: select high, clock low
`define SFL_PIN_IDLE    3'h4

// ----------------------------------------------------------------------
// Length mode encodings and byte counts
// ----------------------------------------------------------------------
`define SFL_MODE_VAR    2'h0
`define SFL_MODE_ONE    2'h1
`define SFL_MODE_TWO    2'h2
`define SFL_MODE_FOUR   2'h3
`define SFL_LEN_VAR     3'h0
`define SFL_LEN_ONE     3'h1
`define SFL_LEN_TWO     3'h2
`define SFL_LEN_FOUR    3'h4

// ----------------------------------------------------------------------
// Register map (byte addresses) and fields
// ----------------------------------------------------------------------
`define SFL_REG_CTRL    4'h0
`define SFL_REG_STATUS  4'h4
`define SFL_REG_COUNT   4'h8
`define SFL_CTRL_EN     0
`define SFL_CTRL_RST    1'h1

`endif

// *** bench/sfl_spi_frame_sva.sv ***
// Purpose: Port assertions for the serial frame engine
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound into every sfl_spi_frame instance
`timescale 1ns/1ps
module sfl_spi_frame_sva (
    input wire        i_clock,
    input wire        i_rst_n,
    input wire        i_frame_select_n,
    input wire        o_miso_oe,
    input wire        o_acc_strobe,
    input wire [3:0]  i_avs_address,
    input wire        i_avs_read,
    input wire        i_avs_write,
    input wire [31:0] o_avs_readdata,
    input wire        o_avs_waitrequest
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire req = i_avs_read | i_avs_write;
    wire unmapped = !(i_avs_address inside {4'h0, 4'h4, 4'h8});

    chk_wait_answer: assert property (req && o_avs_waitrequest
        |=> !o_avs_waitrequest) else $error("bus request not answered");
    chk_wait_one: assert property (!o_avs_waitrequest
        |=> o_avs_waitrequest) else $error("answer longer than a cycle");
    chk_wait_idle: assert property (!req && o_avs_waitrequest
        |=> o_avs_waitrequest) else $error("answer without request");
    chk_unmapped_zero: assert property (i_avs_read && unmapped
        && o_avs_waitrequest |=> o_avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    chk_strobe_gap: assert property (
        o_acc_strobe |=> !o_acc_strobe [*8]) else $error("strobes too close");
    chk_strobe_frame: assert property (
        o_acc_strobe |-> o_miso_oe) else $error("access outside frame");
    chk_oe_rise: assert property (
        $fell(i_frame_select_n) |-> ##[1:8] o_miso_oe)
        else $error("output enable late");
    chk_oe_fall: assert property (
        $rose(i_frame_select_n) |-> ##[1:8] !o_miso_oe)
        else $error("output enable stuck");
    cov_strobe: cover property (o_acc_strobe);
    cov_frame_end: cover property ($rose(i_frame_select_n));
    cov_unmapped: cover property (i_avs_read && unmapped);
endmodule
bind sfl_spi_frame sfl_spi_frame_sva u_sva (.i_clock, .i_rst_n,
    .i_frame_select_n, .o_miso_oe, .o_acc_strobe, .i_avs_address,
    .i_avs_read, .i_avs_write, .o_avs_readdata, .o_avs_waitrequest);

// *** bench/sfl_host_model.sv ***
// Purpose: Serial host that frames accesses to the engine
// Assumes: Mode 0, link clock period 125 ns, idle low between frames
// Notes:   Released data line shows the inverse of its last value
`timescale 1ns/1ps
module sfl_host_model (
    output reg  o_sclk,
    output reg  o_mosi,
    output reg  o_frame_select_n,
    input  wire i_miso
);
    localparam real HALF = 62.5;
    initial begin
        o_sclk = 1'b0;
        o_mosi = 1'b1;
        o_frame_select_n = 1'b1;
    end
    task frame_begin;
        begin
            o_frame_select_n = 1'b0;
            #HALF;
        end
    endtask
    task frame_end;
        begin
            #HALF;
            o_frame_select_n = 1'b1;
            o_mosi = ~o_mosi;
        end
    endtask
    // Bit goes out in the low phase, read bit is taken at the rise
    task xfer_byte(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                o_mosi = tx[i];
                #HALF o_sclk = 1'b1;
                rx[i] = i_miso;
                #HALF o_sclk = 1'b0;
            end
        end
    endtask
    task send_header(input [15:0] off, input [4:0] blk, input dir,
                     input [1:0] mode);
        reg [7:0] d;
        begin
            xfer_byte(off[15:8], d);
            xfer_byte(off[7:0], d);
            xfer_byte({blk, dir, mode}, d);
        end
    endtask
endmodule

// *** bench/sfl_spi_frame_bench.sv ***
// Purpose: Self-checking bench for the serial frame engine
// Assumes: 100 MHz clock, host model on the link side
// Notes:   Target memory answers reads one cycle after the strobe
`timescale 1ns/1ps
module sfl_spi_frame_bench;
    reg         clk, rst_n, rd, wr;
    reg  [3:0]  addr;
    reg  [31:0] wdata;
    reg  [7:0]  rdata_t;
    wire [31:0] rdata;
    wire        wait_r, sclk, mosi, sel_n, miso, oe, strobe, acc_wr;
    wire [4:0]  blk;
    wire [15:0] off;
    wire [7:0]  acc_wd;
    reg  [7:0]  mem [0:255];
    reg  [28:0] log_q [$];
    integer     mismatches, comparisons;

    sfl_host_model host (.o_sclk(sclk), .o_mosi(mosi),
        .o_frame_select_n(sel_n), .i_miso(miso));
    sfl_spi_frame dut (.i_clock(clk), .i_rst_n(rst_n), .i_sclk(sclk),
        .i_mosi(mosi), .i_frame_select_n(sel_n), .o_miso(miso),
        .o_miso_oe(oe), .o_acc_strobe(strobe), .o_acc_write(acc_wr),
        .o_acc_block(blk), .o_acc_offset(off), .o_acc_wdata(acc_wd),
        .i_acc_rdata(rdata_t), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata),
        .o_avs_readdata(rdata), .o_avs_waitrequest(wait_r));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(posedge clk) begin
        rdata_t <= mem[off[7:0]];
        if (strobe && acc_wr) begin
            mem[off[7:0]] <= acc_wd;
            log_q.push_back({blk, off, acc_wd});
        end
    end
    task chk(input string name, input [31:0] exp, input [31:0] got);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                mismatches = mismatches + 1;
                $display("mismatch %s expected %h seen %h", name, exp, got);
            end
        end
    endtask
    task chk_log(input [28:0] exp);
        reg [28:0] got;
        begin
            got = (log_q.size() > 0) ? log_q.pop_front() : 29'h1FFFFFFF;
            chk("write access", {3'h0, exp}, {3'h0, got});
        end
    endtask
    task av(input w, input [3:0] a, input [31:0] d, output [31:0] q);
        integer n;
        begin
            @(posedge clk);
            rd <= !w;
            wr <= w;
            addr <= a;
            wdata <= d;
            n = 0;
            do begin
                @(posedge clk);
                n = n + 1;
            end while (wait_r !== 1'b0 && n < 50);
            q = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
            chk("bus answer", 32'h0, {31'h0, wait_r});
        end
    endtask
    task t_regs;
        reg [31:0] q;
        begin
            av(0, 4'h0, 32'h0, q);
            chk("ctrl reset", 32'h00000001, q);
            av(1, 4'hC, 32'hFFFFFFFF, q);
            av(0, 4'hC, 32'h0, q);
            chk("unmapped", 32'h00000000, q);
            av(1, 4'h0, 32'h00000000, q);
            av(0, 4'h0, 32'h0, q);
            chk("ctrl off", 32'h00000000, q);
            av(1, 4'h0, 32'h00000001, q);
        end
    endtask
    task t_vwrite;
        reg [7:0]  r;
        reg [31:0] q;
        integer    i;
        begin
            host.frame_begin;
            host.send_header(16'h0040, 5'h06, 1'b1, 2'h0);
            for (i = 0; i < 5; i = i + 1)
                host.xfer_byte(8'h11 * (i + 1), r);
            host.frame_end;
            repeat (10) @(posedge clk);
            for (i = 0; i < 5; i = i + 1)
                chk_log({5'h06, 16'(16'h0040 + i),
                         8'(8'h11 * (i + 1))});
            chk("extra writes", 32'h0, log_q.size());
            av(0, 4'h4, 32'h0, q);
            chk("status", 32'h00000034, {16'h0, q[15:0]});
            chk("frames", 32'h1, {16'h0, q[31:16]});
            av(0, 4'h8, 32'h0, q);
            chk("byte count", 32'h5, {16'h0, q[31:16]});
        end
    endtask
    task t_vread;
        reg [7:0] r;
        integer   i;
        begin
            for (i = 0; i < 5; i = i + 1)
                mem[i] = 8'hAA + 8'h11 * i;
            host.frame_begin;
            host.send_header(16'h0100, 5'h0F, 1'b0, 2'h0);
            for (i = 0; i < 5; i = i + 1) begin
                host.xfer_byte(8'h00, r);
                chk("read byte", 8'hAA + 8'h11 * i, {24'h0, r});
            end
            host.frame_end;
            repeat (10) @(posedge clk);
            chk("read wrote", 32'h0, log_q.size());
        end
    endtask
    task t_fixed;
        reg [7:0]  r;
        reg [31:0] q;
        integer    i, m;
        begin
            host.frame_begin;
            for (m = 1; m < 4; m = m + 1) begin
                host.send_header(16'h0010 * m, 5'h01, 1'b1, m[1:0]);
                for (i = 0; i < ((m == 3) ? 4 : m); i = i + 1)
                    host.xfer_byte(8'hC0 + 8'h10 * m + i, r);
            end
            repeat (10) @(posedge clk);
            for (m = 1; m < 4; m = m + 1)
                for (i = 0; i < ((m == 3) ? 4 : m); i = i + 1)
                    chk_log({5'h01, 16'(16'h0010 * m + i),
                             8'(8'hC0 + 8'h10 * m + i)});
            chk("fixed extra", 32'h0, log_q.size());
            host.frame_end;
            av(0, 4'h4, 32'h0, q);
            chk("fixed status", 32'h0000000F, {16'h0, q[15:0]});
            chk("fixed frames", 32'h5, {16'h0, q[31:16]});
        end
    endtask
    task t_fread;
        reg [7:0]  r;
        reg [31:0] q;
        integer    i;
        begin
            mem[8'h20] = 8'h5A;
            mem[8'h21] = 8'hA5;
            host.frame_begin;
            host.send_header(16'h0020, 5'h02, 1'b0, 2'h2);
            for (i = 0; i < 2; i = i + 1) begin
                host.xfer_byte(8'h00, r);
                chk("fixed read", i ? 32'hA5 : 32'h5A, {24'h0, r});
            end
            host.send_header(16'h0021, 5'h02, 1'b0, 2'h1);
            host.xfer_byte(8'h00, r);
            chk("fixed read one", 32'hA5, {24'h0, r});
            host.frame_end;
            repeat (10) @(posedge clk);
            chk("fixed read wrote", 32'h0, log_q.size());
            av(0, 4'h4, 32'h0, q);
            chk("fread status", 32'h00000011, {16'h0, q[15:0]});
            chk("fread frames", 32'h7, {16'h0, q[31:16]});
        end
    endtask
    task report_and_stop;
        begin
            $display("comparisons %0d mismatches %0d", comparisons,
                     mismatches);
            if (mismatches == 0 && comparisons > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask
    initial begin
        #200000;
        mismatches = mismatches + 1;
        report_and_stop;
    end
    initial begin
        rst_n = 1'b0;
        rd = 1'b0;
        wr = 1'b0;
        addr = 4'h0;
        wdata = 32'h0;
        mismatches = 0;
        comparisons = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        t_regs;
        t_vwrite;
        t_vread;
        t_fixed;
        t_fread;
        report_and_stop;
    end
endmodule
